// ---- inc/pimm_defines.vh ----
// constants of the per-interrogator message manager
`ifndef PIMM_DEFINES_VH
`define PIMM_DEFINES_VH
// ****************************
// register byte offsets
// ****************************
`define PIMM_OFS_CTRL 8'h00
`define PIMM_OFS_DLO 8'h04
`define PIMM_OFS_DHI 8'h08
`define PIMM_OFS_CBCMD 8'h0c
`define PIMM_OFS_DLCMD 8'h10
`define PIMM_OFS_STAT 8'h14
`define PIMM_OFS_QUED 8'h18
`define PIMM_OFS_ULSEL 8'h1c
`define PIMM_OFS_ULLO 8'h20
`define PIMM_OFS_ULHI 8'h24
`define PIMM_OFS_ULTAS 8'h28
// ****************************
// field positions
// ****************************
`define PIMM_CB_LAST 6
`define PIMM_STAT_REF 22
// ****************************
// message types and event kinds
// ****************************
`define PIMM_TY_DIR 2'h0
`define PIMM_TY_AICB 2'h1
`define PIMM_TY_BCAST 2'h2
`define PIMM_EV_SURV 3'h0
`define PIMM_EV_CBRD 3'h1
`define PIMM_EV_CBCLS 3'h2
`define PIMM_EV_ULSEG 3'h3
`define PIMM_EV_DLREQ 3'h4
`define PIMM_EV_DLCLS 3'h5
`define PIMM_EV_ULCLS 3'h6
// ****************************
// downlink request codes
// ****************************
`define PIMM_DR_NONE 5'h00
`define PIMM_DR_CB 5'h01
`define PIMM_DR_ACAS 5'h02
`define PIMM_DR_CBACAS 5'h03
`define PIMM_DR_BC 5'h04
`define PIMM_DR_BCACAS 5'h05
// ****************************
// timing
// ****************************
`define PIMM_CLK_KHZ 10000
`define PIMM_TICK_MS 100
`define PIMM_HOLD_S 18
`endif

// ---- design/pimm_seg_ram.v ----
// segment store: one write port, one asynchronous read port
`timescale 1ns/100ps
module pimm_seg_ram #(
   parameter AW = 8,
   parameter DW = 56
) (
   // clock
   input wire mclk,
   // write side
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   // read side
   input wire [AW-1:0] raddr,
   output wire [DW-1:0] rdata
);
   // storage, no reset: replies read contents only once marked valid
   reg [DW-1:0] mem [0:(1<<AW)-1];
   // write process
   always @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
   assign rdata = mem[raddr];
endmodule // pimm_seg_ram

// ---- design/pimm_timer_bank.v ----
// bank of hold timers, one per interrogator code plus one for the air-initiated binding
`timescale 1ns/100ps
`include "pimm_defines.vh"
module pimm_timer_bank (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // time base
   input wire tick,
   // control per entry
   input wire [16:0] start,
   input wire [16:0] clear,
   input wire [16:0] hold,
   // state per entry
   output wire [16:0] active,
   output wire [16:0] expired
);
   // hold time counted in ticks
   localparam integer HOLD_INT = `PIMM_HOLD_S * 1000 / `PIMM_TICK_MS;
   localparam [7:0] HOLD_TICKS = HOLD_INT[7:0]; // hold count fits eight bits
   genvar g;
   generate
      for (g = 0; g < 17; g = g + 1) begin : gTmr
         reg run_ff; // entry running
         reg [7:0] cnt_ff; // ticks elapsed
         reg exp_ff; // one-cycle expiry pulse
         // hold freezes the count, so an interruption does not eat time
         always @(posedge mclk) begin
            exp_ff <= 1'b0;
            if (!resetn) begin
               run_ff <= 1'b0;
               cnt_ff <= 8'h00;
            end else if (start[g]) begin
               run_ff <= 1'b1;
               cnt_ff <= 8'h00;
            end else if (clear[g]) begin
               run_ff <= 1'b0;
            end else if (run_ff && tick && !hold[g]) begin
               if (cnt_ff == HOLD_TICKS - 8'h01) begin
                  run_ff <= 1'b0;
                  exp_ff <= 1'b1;
               end else begin
                  cnt_ff <= cnt_ff + 8'h01;
               end
            end
         end
         assign active[g] = run_ff;
         assign expired[g] = exp_ff;
      end
   endgenerate
endmodule // pimm_timer_bank

// ---- design/pimm_manager.v ----
// per-interrogator comm-b and elm message manager with apb registers
//
// Operation
// (RULE_01) plain scheme: DR 1/3, IIS names destination
// (RULE_02) enhanced: DR and IIS per replying interrogator
// (RULE_03) one announcement per reply, comm-b first
// (RULE_04) closeout reply flags next pending message
// (RULE_05) new air-initiated message goes to code 0
// (RULE_06) unassigned air-initiated announced with IIS 0
// (RULE_07) reader binds air-initiated message until closeout
// (RULE_08) unclosed binding reverts after 18 seconds
// (RULE_09) only one air-initiated message at once; code queues a second behind it and refuses a third
// (RULE_10) only bound interrogator may close it out
// (RULE_11) broadcast held 18 s per code, own timers
// (RULE_12) no new broadcast until all timed out
// (RULE_13) four-segment comm-b store per code
// (RULE_14) acas announced to all with DR 2/3; code gives DR 5 with a broadcast and none with a downlink
// (RULE_15) interrogator sends IIS in every elm uplink
// (RULE_16) uplink code from first four MC bits
// (RULE_17) reassemble uplink by segment number and code
// (RULE_18) technical acknowledgement carries received code
// (RULE_19) uplink closeout clears that code's TAS
// (RULE_20) sixteen uplink segments per code stored
// (RULE_21) sixteen downlink segments per code, IIS selects
// (RULE_22) directed downlink only to its interrogator
// (RULE_23) missing downlink segments sent as zeros
// (RULE_24) busy code queues the next directed message
// (RULE_25) four-bit code indexes all per-code state
`timescale 1ns/100ps
`include "pimm_defines.vh"
module pimm_manager #(
   parameter [19:0] TICK_CYC = `PIMM_TICK_MS * `PIMM_CLK_KHZ
) (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // decoded interrogations
   input wire evtValid,
   input wire [2:0] evtKind,
   input wire [3:0] evtIi,
   input wire [3:0] evtNc,
   input wire evtInit,
   input wire [55:0] evtData,
   // reply content
   output reg rplValid,
   output reg [2:0] rplKind,
   output reg [4:0] rplDr,
   output reg [3:0] rplIis,
   output reg [55:0] rplData,
   output reg [15:0] rplTas
);
   // ****************************
   // state
   // ****************************
   reg enh_ff; // enhanced scheme on
   reg acas_ff; // acas message waiting
   reg [55:0] stage_ff; // software staging word
   reg [15:0] cbBusy_ff; // comm-b store occupied, bit 0 air-initiated
   reg [15:0] cbQued_ff; // second message waiting in other bank
   reg [15:0] bank_ff; // active bank per code
   reg aicbAsg_ff; // air-initiated message bound
   reg [3:0] aicbIi_ff; // code it is bound to
   reg [55:0] bcData_ff; // broadcast content
   reg refused_ff; // sticky: a command was refused
   reg [7:0] ulSel_ff; // uplink readback select {code, seg}
   reg [4:0] dlLen_ff [0:15]; // downlink length per code, 0 = none
   reg [15:0] ulTas_ff [0:15]; // uplink segments seen per code
   reg [19:0] pre_ff; // time base divider
   reg tick_ff; // one-cycle tick every 100 ms
   reg evV_ff; // event stage valid
   reg [2:0] evK_ff; // event stage kind
   reg [3:0] evIi_ff; // event stage code
   reg [3:0] evNc_ff; // event stage segment
   integer m;
   integer k;
   // ****************************
   // apb decode
   // ****************************
   wire apbSet = psel & penable & ~pready; // first access cycle
   wire apbWr = psel & penable & pready & pwrite; // write commits here
   wire hit = (paddr[1:0] == 2'h0) && (paddr <= `PIMM_OFS_ULTAS);
   wire cbCmd = apbWr && (paddr == `PIMM_OFS_CBCMD);
   wire dlCmd = apbWr && (paddr == `PIMM_OFS_DLCMD);
   wire [1:0] cbTy = pwdata[8:7];
   wire cbLast = pwdata[`PIMM_CB_LAST];
   wire [3:0] cbSlot = (cbTy == `PIMM_TY_AICB) ? 4'h0 : pwdata[3:0]; // RULE_05
   // ****************************
   // interrogation decode
   // ****************************
   wire [3:0] evCode = (evtKind == `PIMM_EV_ULSEG) ? evtData[55:52] : evtIi; // RULE_16
   wire cbRd = evtValid && (evtKind == `PIMM_EV_CBRD);
   wire cbCls = evtValid && (evtKind == `PIMM_EV_CBCLS);
   wire [15:0] dirPend = cbBusy_ff & 16'hfffe;
   // air-initiated closeout only from the bound code
   wire aiCls = cbCls && aicbAsg_ff && (aicbIi_ff == evtIi); // RULE_10
   wire dirCls = cbCls && (evtIi != 4'h0) && cbBusy_ff[evtIi];
   wire [3:0] clsSlot = aiCls ? 4'h0 : evtIi;
   wire clsAny = aiCls | dirCls;
   // read from a code with nothing directed binds the air message
   wire aiBind = cbRd && cbBusy_ff[0] && !aicbAsg_ff && !dirPend[evtIi]; // RULE_07
   // ****************************
   // timers
   // ****************************
   wire [16:0] tAct;
   wire [16:0] tExp;
   wire bcBusy = |tAct[15:0];
   // refusal: code already has one queued, directed to code 0, or broadcast while one runs
   wire cbRef = cbCmd && ((cbTy == `PIMM_TY_BCAST) ? (cbLast && bcBusy) : // RULE_12
      (cbQued_ff[cbSlot] || (cbTy == `PIMM_TY_DIR && cbSlot == 4'h0))); // RULE_09
   wire bcStart = cbCmd && cbLast && (cbTy == `PIMM_TY_BCAST) && !bcBusy;
   pimm_timer_bank uTmr (
      .mclk(mclk),
      .resetn(resetn),
      .tick(tick_ff),
      .start({aiBind, {16{bcStart}}}), // RULE_11
      .clear({aiCls, 16'h0000}),
      .hold({1'b0, dirPend}), // RULE_11
      .active(tAct),
      .expired(tExp)
   );
   // time base divider
   always @(posedge mclk) begin
      if (!resetn) begin
         pre_ff <= 20'h00000;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (pre_ff == TICK_CYC - 20'h00001);
         pre_ff <= (pre_ff == TICK_CYC - 20'h00001) ? 20'h00000 : pre_ff + 20'h00001;
      end
   end
   // ****************************
   // comm-b store bookkeeping
   // ****************************
   // a closeout and a commit to one code with nothing queued, same cycle: the closeout
   // frees first, so the commit lands as the new active message
   wire freed = clsAny && (clsSlot == cbSlot) && !cbQued_ff[cbSlot];
   always @(posedge mclk) begin
      if (!resetn) begin
         cbBusy_ff <= 16'h0000;
         cbQued_ff <= 16'h0000;
         bank_ff <= 16'h0000;
         aicbAsg_ff <= 1'b0;
         aicbIi_ff <= 4'h0;
         bcData_ff <= 56'h0;
      end else begin
         // closeout: swap in queued message or free the store
         if (clsAny) begin
            if (cbQued_ff[clsSlot]) begin
               cbQued_ff[clsSlot] <= 1'b0; // RULE_24
               bank_ff[clsSlot] <= ~bank_ff[clsSlot];
            end else begin
               cbBusy_ff[clsSlot] <= 1'b0;
            end
         end
         // air message binding and its timeout
         if (aiCls) begin
            aicbAsg_ff <= 1'b0;
         end else if (tExp[16]) begin
            aicbAsg_ff <= 1'b0; // RULE_08
         end else if (aiBind) begin
            aicbAsg_ff <= 1'b1; // RULE_07
            aicbIi_ff <= evtIi;
         end
         // software commit of a message
         if (cbCmd && cbLast && !cbRef) begin
            if (cbTy == `PIMM_TY_BCAST) begin
               bcData_ff <= stage_ff;
            end else if (cbBusy_ff[cbSlot] && !freed) begin
               cbQued_ff[cbSlot] <= 1'b1; // RULE_24
            end else begin
               cbBusy_ff[cbSlot] <= 1'b1;
               bank_ff[cbSlot] <= ~bank_ff[cbSlot];
            end
         end
      end
   end
   // ****************************
   // software registers
   // ****************************
   always @(posedge mclk) begin
      if (!resetn) begin
         enh_ff <= 1'b0;
         acas_ff <= 1'b0;
         stage_ff <= 56'h0;
         ulSel_ff <= 8'h00;
         refused_ff <= 1'b0;
      end else begin
         if (apbWr && paddr == `PIMM_OFS_CTRL) begin
            enh_ff <= pwdata[0];
            acas_ff <= pwdata[1];
         end
         if (apbWr && paddr == `PIMM_OFS_DLO) begin
            stage_ff[31:0] <= pwdata;
         end
         if (apbWr && paddr == `PIMM_OFS_DHI) begin
            stage_ff[55:32] <= pwdata[23:0];
         end
         if (apbWr && paddr == `PIMM_OFS_ULSEL) begin
            ulSel_ff <= pwdata[7:0];
         end
         // set wins over the write-one clear
         refused_ff <= (refused_ff & ~(apbWr && paddr == `PIMM_OFS_STAT && pwdata[`PIMM_STAT_REF])) | cbRef;
      end
   end
   // ****************************
   // elm state per code
   // ****************************
   wire ulSeg = evtValid && (evtKind == `PIMM_EV_ULSEG);
   wire [3:0] dlSlot = (pwdata[13] || pwdata[3:0] == 4'h0) ? 4'h0 : pwdata[3:0];
   always @(posedge mclk) begin
      if (!resetn) begin
         for (m = 0; m < 16; m = m + 1) begin
            dlLen_ff[m] <= 5'h00;
            ulTas_ff[m] <= 16'h0000;
         end
      end else begin
         // downlink closeout clears the directed store, else the shared one
         if (evtValid && evtKind == `PIMM_EV_DLCLS) begin
            if (evtIi != 4'h0 && dlLen_ff[evtIi] != 5'h00) begin
               dlLen_ff[evtIi] <= 5'h00;
            end else begin
               dlLen_ff[0] <= 5'h00;
            end
         end
         // posting a length makes the downlink message live
         if (dlCmd && pwdata[12:8] != 5'h00) begin
            dlLen_ff[dlSlot] <= pwdata[12:8]; // RULE_21
         end
         // uplink: initial segment restarts the record for that code
         if (evtValid && evtKind == `PIMM_EV_ULCLS) begin
            ulTas_ff[evtIi] <= 16'h0000; // RULE_19
         end
         if (ulSeg) begin
            ulTas_ff[evCode] <= (evtInit ? 16'h0000 : ulTas_ff[evCode]) | (16'h0001 << evtNc); // RULE_17
         end
      end
   end
   // ****************************
   // segment stores
   // ****************************
   wire [55:0] cbRd_d;
   wire [55:0] ulRd_d;
   wire [55:0] dlRd_d;
   reg [6:0] cbRa;
   reg [7:0] dlRa;
   // new segments go to the idle bank, a queued one cannot be overwritten
   pimm_seg_ram #(.AW(7), .DW(56)) uCb (
      .mclk(mclk),
      .we(cbCmd && cbTy != `PIMM_TY_BCAST && !cbRef), // RULE_13
      .waddr({~bank_ff[cbSlot], cbSlot, pwdata[5:4]}),
      .wdata(stage_ff),
      .raddr(cbRa),
      .rdata(cbRd_d)
   );
   pimm_seg_ram #(.AW(8), .DW(56)) uUl (
      .mclk(mclk),
      .we(ulSeg), // RULE_20
      .waddr({evCode, evtNc}),
      .wdata(evtData),
      .raddr(ulSel_ff),
      .rdata(ulRd_d)
   );
   pimm_seg_ram #(.AW(8), .DW(56)) uDl (
      .mclk(mclk),
      .we(dlCmd),
      .waddr({dlSlot, pwdata[7:4]}),
      .wdata(stage_ff),
      .raddr(dlRa),
      .rdata(dlRd_d)
   );
   // ****************************
   // event stage
   // ****************************
   // the reply is formed one cycle late so it sees the updated state
   always @(posedge mclk) begin
      if (!resetn) begin
         evV_ff <= 1'b0;
         evK_ff <= 3'h0;
         evIi_ff <= 4'h0;
         evNc_ff <= 4'h0;
      end else begin
         evV_ff <= evtValid;
         evK_ff <= evtKind;
         evIi_ff <= evCode; // RULE_25
         evNc_ff <= evtNc;
      end
   end
   // ****************************
   // announcement logic
   // ****************************
   reg [3:0] lowIi; // plain scheme: first waiting code
   reg dirW;
   reg [3:0] dirIi;
   reg aiW;
   reg dlW;
   reg [4:0] dlLenSel;
   reg [3:0] dlIdx;
   reg [4:0] nxt_dr;
   reg [3:0] nxt_iis;
   reg [55:0] nxt_data;
   wire dirHere = dirPend[evIi_ff];
   wire dlHere = (evIi_ff != 4'h0) && (dlLen_ff[evIi_ff] != 5'h00);
   always @* begin
      lowIi = 4'h0;
      for (k = 15; k >= 1; k = k - 1) begin
         if (dirPend[k]) begin
            lowIi = k[3:0];
         end
      end
      // plain: same word to all; enhanced: per interrogator
      dirW = enh_ff ? dirHere : (|dirPend); // RULE_01 RULE_02
      dirIi = enh_ff ? evIi_ff : lowIi;
      // air message: unbound to all free codes, bound only to owner
      aiW = cbBusy_ff[0] && (aicbAsg_ff ? (aicbIi_ff == evIi_ff) : !dirHere); // RULE_06
      // directed downlink only to owner, shared one to codes with nothing directed
      dlIdx = dlHere ? evIi_ff : 4'h0; // RULE_22
      dlLenSel = dlLen_ff[dlIdx];
      dlW = dlHere || (dlLen_ff[0] != 5'h00 && !dirHere);
      nxt_iis = 4'h0;
      // comm-b ahead of broadcast, downlink and acas alone
      if (dirW || aiW) begin
         nxt_dr = acas_ff ? `PIMM_DR_CBACAS : `PIMM_DR_CB; // RULE_03 RULE_04 RULE_14
         nxt_iis = dirW ? dirIi : (aicbAsg_ff ? aicbIi_ff : 4'h0); // RULE_06
      end else if (tAct[evIi_ff]) begin
         nxt_dr = acas_ff ? `PIMM_DR_BCACAS : `PIMM_DR_BC;
      end else if (dlW) begin
         nxt_dr = {1'b1, dlLenSel[3:0] - 4'h1}; // RULE_03
         nxt_iis = dlIdx;
      end else if (acas_ff) begin
         nxt_dr = `PIMM_DR_ACAS; // RULE_14
      end else begin
         nxt_dr = `PIMM_DR_NONE; // RULE_02
      end
      // segment reads for the reply
      cbRa = dirHere ? {bank_ff[evIi_ff], evIi_ff, evNc_ff[1:0]} : {bank_ff[0], 4'h0, evNc_ff[1:0]};
      dlRa = {dlIdx, evNc_ff};
      nxt_data = 56'h0;
      if (evK_ff == `PIMM_EV_CBRD) begin
         if (dirHere || aiW) begin
            nxt_data = cbRd_d;
         end else if (tAct[evIi_ff]) begin
            nxt_data = bcData_ff;
         end
      end else if (evK_ff == `PIMM_EV_DLREQ) begin
         // beyond the posted length, or nothing posted: zeros
         nxt_data = ({1'b0, evNc_ff} < dlLenSel) ? dlRd_d : 56'h0; // RULE_23 RULE_21
      end
      // uplink acknowledgement echoes the code it came with
      if (evK_ff == `PIMM_EV_ULSEG || evK_ff == `PIMM_EV_ULCLS) begin
         nxt_iis = evIi_ff; // RULE_18
      end
   end
   // reply registers
   always @(posedge mclk) begin
      if (!resetn) begin
         rplValid <= 1'b0;
         rplKind <= 3'h0;
         rplDr <= 5'h00;
         rplIis <= 4'h0;
         rplData <= 56'h0;
         rplTas <= 16'h0000;
      end else begin
         rplValid <= evV_ff;
         // fields move only with a reply, so idle state changes stay hidden
         if (evV_ff) begin
            rplKind <= evK_ff;
            rplDr <= nxt_dr;
            rplIis <= nxt_iis;
            rplData <= nxt_data;
            rplTas <= ulTas_ff[evIi_ff]; // RULE_18
         end
      end
   end
   // ****************************
   // apb read and answer
   // ****************************
   wire [15:0] dlMask;
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : gDl
         assign dlMask[g] = (dlLen_ff[g] != 5'h00);
      end
   endgenerate
   reg [31:0] rdMux;
   always @* begin
      case (paddr)
         `PIMM_OFS_CTRL: rdMux = {30'h0, acas_ff, enh_ff};
         `PIMM_OFS_DLO: rdMux = stage_ff[31:0];
         `PIMM_OFS_DHI: rdMux = {8'h00, stage_ff[55:32]};
         `PIMM_OFS_STAT: rdMux = {9'h000, refused_ff, bcBusy, aicbIi_ff, aicbAsg_ff, cbBusy_ff};
         `PIMM_OFS_QUED: rdMux = {dlMask, cbQued_ff};
         `PIMM_OFS_ULSEL: rdMux = {24'h000000, ulSel_ff};
         `PIMM_OFS_ULLO: rdMux = ulRd_d[31:0];
         `PIMM_OFS_ULHI: rdMux = {8'h00, ulRd_d[55:32]};
         `PIMM_OFS_ULTAS: rdMux = {16'h0000, ulTas_ff[ulSel_ff[7:4]]};
         default: rdMux = 32'h00000000;
      endcase
   end
   // one wait state keeps every apb output on a flip-flop
   always @(posedge mclk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apbSet;
         pslverr <= apbSet && !hit;
         prdata <= (apbSet && !pwrite) ? rdMux : 32'h00000000;
      end
   end
endmodule // pimm_manager

// ---- testbench/pimm_checker.sv ----
// port assertions for the message manager
`timescale 1ns/100ps
module pimm_checker (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // apb
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // events and replies
   input wire evtValid,
   input wire [2:0] evtKind,
   input wire [55:0] evtData,
   input wire rplValid,
   input wire [2:0] rplKind,
   input wire [4:0] rplDr,
   input wire [3:0] rplIis,
   input wire [55:0] rplData,
   input wire [15:0] rplTas
);
   // uplink code rides in the payload head
   wire [3:0] ulCode = evtData[55:52];
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_lat; evtValid |-> ##2 rplValid; endproperty
   a_lat: assert property (p_lat)
      else $error("reply missing");
   property p_kind; rplValid |-> $past(evtValid, 2) && rplKind == $past(evtKind, 2); endproperty
   a_kind: assert property (p_kind)
      else $error("reply kind wrong");
   property p_ack; rplValid && rplKind == 3'h3 |-> rplIis == $past(ulCode, 2); endproperty
   a_ack: assert property (p_ack)
      else $error("ack code wrong");
   property p_tas; rplValid && rplKind == 3'h6 |-> rplTas == 16'h0; endproperty
   a_tas: assert property (p_tas)
      else $error("tas not cleared");
   property p_dr; rplValid |-> rplDr < 5'h06 || rplDr[4]; endproperty
   a_dr: assert property (p_dr)
      else $error("bad dr code");
   property p_hold; !rplValid |-> $stable(rplDr) && $stable(rplIis) && $stable(rplData); endproperty
   a_hold: assert property (p_hold)
      else $error("reply moved");
   property p_rdy; psel && !penable |=> !pready ##1 pready; endproperty
   a_rdy: assert property (p_rdy)
      else $error("wait state wrong");
   property p_err; pready |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0); endproperty
   a_err: assert property (p_err)
      else $error("slave error wrong");
   property p_rd0; !pready |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0)
      else $error("read data leaks");
   c_ack: cover property (rplValid && rplKind == 3'h3);
   c_err: cover property (pready && pslverr);
   c_dl: cover property (rplValid && rplDr[4]);
endmodule // pimm_checker
bind pimm_manager pimm_checker chk (.mclk, .resetn, .psel, .penable, .paddr, .prdata, .pready,
   .pslverr, .evtValid, .evtKind, .evtData, .rplValid, .rplKind, .rplDr, .rplIis, .rplData, .rplTas);

// ---- testbench/pimm_interrogator.sv ----
// ground interrogator model driving decoded events
`timescale 1ns/100ps
module pimm_interrogator (
   // clock
   input wire mclk,
   // decoded interrogation
   output reg evtValid,
   output reg [2:0] evtKind,
   output reg [3:0] evtIi,
   output reg [3:0] evtNc,
   output reg evtInit,
   output reg [55:0] evtData
);
   initial {evtValid, evtKind, evtIi, evtNc, evtInit, evtData} = 69'h0;
   // one interrogation, one cycle long
   task send(input [2:0] k, input [3:0] i, input [3:0] n, input s, input [55:0] d);
      @(posedge mclk);
      {evtValid, evtKind, evtIi, evtNc, evtInit, evtData} <= {1'b1, k, i, n, s, d};
      @(posedge mclk);
      evtValid <= 1'b0;
      // released data and code lines must not keep a usable value
      evtData <= ~d;
      evtIi <= ~i;
   endtask
   // uplink segment: code leads payload, segment 0 starts
   task ulseg(input [3:0] c, input [3:0] n, input [51:0] p);
      send(3'h3, ~c, n, n == 4'h0, {c, p});
   endtask
endmodule // pimm_interrogator

// ---- testbench/pimm_manager_test.sv ----
// self-checking bench for the message manager
`timescale 1ns/100ps
`include "pimm_defines.vh"
module pimm_manager_test;
   reg mclk = 1'b0;
   reg resetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h0;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, evtValid, evtInit, rplValid;
   wire [2:0] evtKind, rplKind;
   wire [3:0] evtIi, evtNc, rplIis;
   wire [55:0] evtData, rplData;
   wire [4:0] rplDr;
   wire [15:0] rplTas;
   reg [129:0] expQ[$]; // mask then value
   integer n_errors = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer seed = 32'h0758;
   integer k;
   reg [3:0] code;
   reg [31:0] r, r5;
   // short tick so the 18 s holds take 1800 cycles
   pimm_manager #(.TICK_CYC(20'd10)) uut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .evtValid, .evtKind, .evtIi, .evtNc, .evtInit, .evtData,
      .rplValid, .rplKind, .rplDr, .rplIis, .rplData, .rplTas);
   pimm_interrogator ifm (.mclk, .evtValid, .evtKind, .evtIi, .evtNc, .evtInit, .evtData);
   initial begin
      forever #50 mclk = ~mclk;
   end
   task finish_test;
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         finish_test;
      end
   end
   task cmp(input string nm, input [64:0] act);
      reg [129:0] e;
      e = expQ.size() ? expQ.pop_front() : {130{1'b1}};
      comparisons = comparisons + 1;
      if ((act & e[129:65]) !== e[64:0]) begin
         n_errors = n_errors + 1;
         $display("ERROR %s expected %h seen %h", nm, e[64:0], act & e[129:65]);
      end
   endtask
   // watcher: oldest note against each result
   always @(posedge mclk)
      if (resetn === 1'b1) begin
         if (rplValid === 1'b1)
            cmp("reply", {rplDr, rplIis, rplData});
         if (pready === 1'b1 && pwrite === 1'b0)
            cmp("prdata", {33'h0, prdata});
      end
   // apb transfer held until pready
   task apb(input w, input [7:0] a, input [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input [7:0] a, input [31:0] m, input [31:0] v);
      expQ.push_back({33'h0, m, 33'h0, v & m});
      apb(1'b0, a, 32'h0);
   endtask
   // s picks dr, iis, zero data
   task note(input [2:0] s, input [4:0] dr, input [3:0] iis);
      reg [64:0] m;
      m = {{5{s[2]}}, {4{s[1]}}, {56{s[0]}}};
      expQ.push_back({m, {dr, iis, 56'h0} & m});
   endtask
   task ev(input [2:0] kd, input [3:0] i, input [3:0] n, input [2:0] s, input [4:0] dr, input [3:0] iis);
      note(s, dr, iis);
      ifm.send(kd, i, n, 1'b0, 56'h0);
   endtask
   task cbmsg(input [31:0] cmd);
      apb(1'b1, `PIMM_OFS_DLO, $random(seed));
      apb(1'b1, `PIMM_OFS_DHI, $random(seed));
      apb(1'b1, `PIMM_OFS_CBCMD, cmd);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      rd(`PIMM_OFS_CTRL, 32'h3, 32'h0);
      cbmsg(32'h40);
      rd(`PIMM_OFS_STAT, 32'h400000, 32'h400000);
      apb(1'b1, `PIMM_OFS_STAT, 32'h400000);
      cbmsg(32'h42);
      ev(0, 5, 0, 6, 5'h01, 4'h2);
      apb(1'b1, `PIMM_OFS_CTRL, 32'h1);
      apb(1'b1, `PIMM_OFS_DLCMD, 32'h206);
      apb(1'b1, `PIMM_OFS_DLCMD, 32'h202);
      ev(0, 2, 0, 6, 5'h01, 4'h2);
      ev(0, 6, 0, 4, 5'h11, 4'h0);
      ev(0, 5, 0, 4, 5'h00, 4'h0);
      ev(4, 6, 3, 1, 5'h00, 4'h0);
      cbmsg(32'hc0);
      ev(2, 2, 0, 6, 5'h01, 4'h0);
      ev(0, 9, 0, 6, 5'h01, 4'h0);
      ev(1, 9, 0, 2, 5'h00, 4'h9);
      ev(0, 11, 0, 4, 5'h00, 4'h0);
      ev(2, 11, 0, 4, 5'h00, 4'h0);
      rd(`PIMM_OFS_STAT, 32'h1f0001, 32'h130001);
      ev(2, 9, 0, 4, 5'h00, 4'h0);
      cbmsg(32'hc0);
      ev(1, 3, 0, 2, 5'h00, 4'h3);
      repeat (1700) @(posedge mclk);
      ev(0, 4, 0, 4, 5'h00, 4'h0);
      repeat (150) @(posedge mclk);
      ev(0, 4, 0, 6, 5'h01, 4'h0);
      ev(1, 4, 0, 2, 5'h00, 4'h4);
      ev(2, 4, 0, 4, 5'h00, 4'h0);
      ev(5, 6, 0, 4, 5'h00, 4'h0);
      ev(5, 2, 0, 4, 5'h00, 4'h0);
      cbmsg(32'h140);
      ev(0, 7, 0, 4, 5'h04, 4'h0);
      cbmsg(32'h140);
      rd(`PIMM_OFS_STAT, 32'h600000, 32'h600000);
      apb(1'b1, `PIMM_OFS_STAT, 32'h400000);
      repeat (1850) @(posedge mclk);
      rd(`PIMM_OFS_STAT, 32'h200000, 32'h0);
      apb(1'b1, `PIMM_OFS_CTRL, 32'h3);
      ev(0, 12, 0, 4, 5'h02, 4'h0);
      r = $random(seed);
      code = r[3:0];
      for (k = 0; k < 16; k = k + 1) begin
         r = $random(seed);
         if (k == 5)
            r5 = r;
         note(2, 5'h0, code);
         ifm.ulseg(code, k[3:0], {20'h0, r});
      end
      apb(1'b1, `PIMM_OFS_ULSEL, {24'h0, code, 4'h5});
      rd(`PIMM_OFS_ULLO, 32'hffffffff, r5);
      rd(`PIMM_OFS_ULTAS, 32'hffff, 32'hffff);
      ev(6, code, 0, 6, 5'h02, code);
      rd(`PIMM_OFS_ULTAS, 32'hffff, 32'h0);
      apb(1'b1, 8'h30, 32'h0);
      repeat (4) @(posedge mclk);
      finish_test;
   end
endmodule // pimm_manager_test
